/* rtl/aio_pkg.sv */
package aio_pkg;
    // Converter and parameter widths
    localparam int ADC_W = 12;
    localparam int DAC_W = 12;
    localparam int PCT_W = 7;
    localparam int SRC_W = 4;
    localparam int TENTHS_W = 10;
    localparam int SRC_SEL_W = 4;
    localparam logic [ADC_W-1:0] ADC_FULL = 12'hfff;
    localparam logic [DAC_W-1:0] DAC_FULL = 12'hfff;
    localparam logic [PCT_W-1:0] PCT_HUNDRED = 7'h64;
    localparam logic [PCT_W-1:0] PCT_ONE = 7'h01;
    localparam logic [PCT_W-1:0] PCT_OFFSET_MAX = 7'h63;

    // Trip kind encodings
    typedef enum logic [1:0] {
        AIO_TRIP_OFF  = 2'b00,
        AIO_TRIP_LOW  = 2'b01,
        AIO_TRIP_HIGH = 2'b10
    } aio_trip_kind_e;

    // Output source codes
    localparam logic [SRC_SEL_W-1:0] SRC_OFF     = 4'h0;
    localparam logic [SRC_SEL_W-1:0] SRC_CUR100  = 4'h1;
    localparam logic [SRC_SEL_W-1:0] SRC_CUR200  = 4'h2;
    localparam logic [SRC_SEL_W-1:0] SRC_CUR800  = 4'h3;
    localparam logic [SRC_SEL_W-1:0] SRC_VOLT150 = 4'h4;
    localparam logic [SRC_SEL_W-1:0] SRC_OL150   = 4'h5;
    localparam logic [SRC_SEL_W-1:0] SRC_KW10    = 4'h6;
    localparam logic [SRC_SEL_W-1:0] SRC_KW100   = 4'h7;
    localparam logic [SRC_SEL_W-1:0] SRC_MW1     = 4'h8;
    localparam logic [SRC_SEL_W-1:0] SRC_MW10    = 4'h9;
    localparam logic [SRC_SEL_W-1:0] SRC_AIN     = 4'ha;
    localparam logic [SRC_SEL_W-1:0] SRC_FIRING  = 4'hb;
    localparam logic [SRC_SEL_W-1:0] SRC_CAL     = 4'hc;

    // Timing
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TRIP_DELAY_UNIT_MS = 100;
    localparam int AOUT_REFRESH_MS = 25;
    localparam logic [PCT_W-1:0] TRIP_LEVEL_DEFAULT_PCT = 7'h32;
    localparam logic [TENTHS_W-1:0] TRIP_DELAY_DEFAULT = 10'h001;
    localparam logic [TENTHS_W-1:0] TRIP_DELAY_MAX = 10'h384;
endpackage

/* rtl/aio_tick_gen.sv */
`timescale 1ns/100ps
`default_nettype none
// Divider producing one-cycle enable pulses every DIV cycles
module aio_tick_gen #(
    parameter int DIV = 125000
) (
    input  wire logic clk,
    input  wire logic rst_b,
    output logic      tick
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          tick_reg;
    logic          tick_next;

    // Below two cycles the pulse could never fall between wraps
    if (DIV < 2) begin : g_bad_div
        $error("aio_tick_gen: DIV must be at least 2");
    end

    // Wrap counter; pulse on wrap
    always_comb begin
        tick_next = 1'b0;
        cnt_next  = cnt_reg + 1'b1;
        if (cnt_reg == CW'(DIV - 1)) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule
`default_nettype wire

/* rtl/aio_scaler.sv */
`timescale 1ns/100ps
`default_nettype none
// Offset and span scaling of the raw input with clamping to 0..full scale
module aio_scaler
    import aio_pkg::*;
(
    input  wire logic [ADC_W-1:0] raw,
    input  wire logic [PCT_W-1:0] zero_shift,
    input  wire logic [PCT_W-1:0] span,
    output logic      [ADC_W-1:0] scaled
);
    logic [ADC_W+PCT_W-1:0] raw_pct;
    logic [ADC_W+PCT_W-1:0] off_pct;
    logic [ADC_W+PCT_W-1:0] diff;
    logic [ADC_W+PCT_W-1:0] quot;
    logic [PCT_W-1:0]       span_safe;

    // Work in raw*100 units so offset percent compares directly
    always_comb begin
        span_safe = (span < PCT_ONE) ? PCT_ONE : span;
        raw_pct   = (ADC_W+PCT_W)'(raw) * (ADC_W+PCT_W)'(PCT_HUNDRED);
        off_pct   = (ADC_W+PCT_W)'(ADC_FULL) * (ADC_W+PCT_W)'(zero_shift);
        diff      = (raw_pct > off_pct) ? raw_pct - off_pct : '0;
        quot      = diff / (ADC_W+PCT_W)'(span_safe);
        scaled    = (quot > (ADC_W+PCT_W)'(ADC_FULL)) ? ADC_FULL : quot[ADC_W-1:0];
    end
endmodule
`default_nettype wire

/* rtl/aio_core.sv */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Trip kind selects off, low or high; off after reset.
// - Low kind trips when input stays below threshold longer than delay.
// - High kind trips when input stays above threshold longer than delay.
// - Comparator and timer only work while the motor runs.
// - Threshold is 0 to 100 percent of full scale, default 50.
// - Trip compares the raw input, ignoring offset and span.
// - Trip delay is 0.1 to 90.0 seconds, default 0.1.
// - Input span is 1 to 100 percent, default 100.
// - Scaled reading is raw fraction minus offset, divided by span.
// - Input offset is 0 to 99 percent, default 0.
// - An input equal to the offset fraction reads zero.
// - Scaled reading saturates at 100 percent.
// - Scaled reading saturates at 0 percent.
// - Codes 1-5 map current 100/200/800, voltage 150, thermal load 150.
// - Codes 6-9 map power at 10 kW, 100 kW, 1 MW, 10 MW.
// - Code 10 outputs the scaled input reading.
// - Code 11 outputs motor voltage from firing angle.
// - Calibration forces full scale; code 0 disables output.
// - Analog output is refreshed every 25 ms.
module aio_core
    import aio_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic [ADC_W-1:0]     ain_raw,
    input  wire logic                 motor_running,
    input  wire logic [1:0]           param_input_trip_kind,
    input  wire logic [PCT_W-1:0]     param_input_trip_threshold,
    input  wire logic [TENTHS_W-1:0]  param_input_trip_delay,
    input  wire logic [PCT_W-1:0]     param_input_scale_span,
    input  wire logic [PCT_W-1:0]     param_input_zero_shift,
    input  wire logic [SRC_SEL_W-1:0] param_output_source_select,
    input  wire logic [15:0]          current_pct,
    input  wire logic [15:0]          voltage_pct,
    input  wire logic [15:0]          thermal_load_content,
    input  wire logic [31:0]          power_w,
    input  wire logic [15:0]          firing_pct,
    output logic      [ADC_W-1:0]     ain_scaled,
    output logic                      input_trip,
    output logic      [DAC_W-1:0]     aout_value,
    output logic                      aout_update
);
    localparam int MS_PER_TENTH = TRIP_DELAY_UNIT_MS;
    localparam int MS_CNT_W = $clog2(MS_PER_TENTH);
    localparam int REF_CNT_W = $clog2(AOUT_REFRESH_MS);
    localparam logic [MS_CNT_W-1:0] MS_TENTH_LAST = MS_CNT_W'(MS_PER_TENTH - 1);
    localparam logic [REF_CNT_W-1:0] REFRESH_LAST = REF_CNT_W'(AOUT_REFRESH_MS - 1);

    // Full-scale points of the output functions, in each source's own units
    localparam logic [31:0] FS_CUR100  = 32'h64;
    localparam logic [31:0] FS_CUR200  = 32'hc8;
    localparam logic [31:0] FS_CUR800  = 32'h320;
    localparam logic [31:0] FS_VOLT150 = 32'h96;
    localparam logic [31:0] FS_OL150   = 32'h96;
    localparam logic [31:0] FS_KW10    = 32'h2710;    // Watts
    localparam logic [31:0] FS_KW100   = 32'h186a0;
    localparam logic [31:0] FS_MW1     = 32'hf4240;
    localparam logic [31:0] FS_MW10    = 32'h989680;
    localparam logic [31:0] FS_FIRING  = 32'h64;

    // The millisecond divider needs at least two cycles per pulse
    if (TICK_DIV < 2) begin : g_bad_div
        $error("aio_core: TICK_DIV too small");
    end

    // Asynchronous pins pass two flops; the converter word gets a third stage
    // so that a word caught mid-change never reaches the scaler or comparator
    logic [ADC_W-1:0] ain_s1_reg;
    logic [ADC_W-1:0] ain_s2_reg;
    logic [ADC_W-1:0] ain_s3_reg;
    logic [ADC_W-1:0] ain_hold_reg;
    logic [ADC_W-1:0] ain_hold_next;
    logic             run_s1_reg;
    logic             run_s2_reg;

    // Take the word only when two samples agree; a code that moves every
    // clock keeps the last settled value, which is fine for a slow sensor
    always_comb begin
        ain_hold_next = (ain_s2_reg == ain_s3_reg) ? ain_s2_reg : ain_hold_reg;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ain_s1_reg   <= '0;
            ain_s2_reg   <= '0;
            ain_s3_reg   <= '0;
            ain_hold_reg <= '0;
            run_s1_reg   <= 1'b0;
            run_s2_reg   <= 1'b0;
        end else begin
            ain_s1_reg   <= ain_raw;
            ain_s2_reg   <= ain_s1_reg;
            ain_s3_reg   <= ain_s2_reg;
            ain_hold_reg <= ain_hold_next;
            run_s1_reg   <= motor_running;
            run_s2_reg   <= run_s1_reg;
        end
    end

    logic ms_tick;
    aio_tick_gen #(.DIV(TICK_DIV)) u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (ms_tick)
    );

    // Settings clamped to their legal ranges; unknown kind acts as off
    logic [PCT_W-1:0]    span_c;
    logic [PCT_W-1:0]    shift_c;
    logic [PCT_W-1:0]    thr_c;
    logic [TENTHS_W-1:0] delay_c;
    aio_trip_kind_e      kind_c;
    always_comb begin
        span_c  = (param_input_scale_span > PCT_HUNDRED) ? PCT_HUNDRED : param_input_scale_span;
        shift_c = (param_input_zero_shift > PCT_OFFSET_MAX) ? PCT_OFFSET_MAX : param_input_zero_shift;
        thr_c   = (param_input_trip_threshold > PCT_HUNDRED) ? PCT_HUNDRED
                                                            : param_input_trip_threshold;
        delay_c = param_input_trip_delay;
        if (delay_c < TRIP_DELAY_DEFAULT) delay_c = TRIP_DELAY_DEFAULT;
        if (delay_c > TRIP_DELAY_MAX) delay_c = TRIP_DELAY_MAX;
        case (param_input_trip_kind)
            2'b01:   kind_c = AIO_TRIP_LOW;
            2'b10:   kind_c = AIO_TRIP_HIGH;
            default: kind_c = AIO_TRIP_OFF;
        endcase
    end

    logic [ADC_W-1:0] scaled_w;
    aio_scaler u_scale (
        .raw        (ain_hold_reg),
        .zero_shift (shift_c),
        .span       (span_c),
        .scaled     (scaled_w)
    );

    // Raw compare in raw*100 units, unaffected by span or offset
    logic [ADC_W+PCT_W-1:0] raw_x100;
    logic [ADC_W+PCT_W-1:0] thr_x_full;
    logic                   below;
    logic                   above;
    logic                   cond;
    always_comb begin
        raw_x100   = (ADC_W+PCT_W)'(ain_hold_reg) * (ADC_W+PCT_W)'(PCT_HUNDRED);
        thr_x_full = (ADC_W+PCT_W)'(ADC_FULL) * (ADC_W+PCT_W)'(thr_c);
        below      = raw_x100 < thr_x_full;
        above      = raw_x100 > thr_x_full;
        case (kind_c)
            AIO_TRIP_LOW:  cond = below;
            AIO_TRIP_HIGH: cond = above;
            default:       cond = 1'b0;
        endcase
    end

    // Trip delay timer: ms prescaler and tenth-second count
    logic [MS_CNT_W-1:0] ms_cnt_reg;
    logic [MS_CNT_W-1:0] ms_cnt_next;
    logic [TENTHS_W-1:0] tenth_reg;
    logic [TENTHS_W-1:0] tenth_next;
    logic                trip_reg;
    logic                trip_next;
    logic [1:0]          kind_last_reg;
    logic                restart;
    always_comb begin
        ms_cnt_next = ms_cnt_reg;
        tenth_next  = tenth_reg;
        trip_next   = trip_reg;
        restart     = !cond || !run_s2_reg || (kind_last_reg != kind_c);
        if (!run_s2_reg) begin
            trip_next = 1'b0;
        end
        if (restart) begin
            ms_cnt_next = '0;
            tenth_next  = '0;
        end else if (ms_tick) begin
            if (ms_cnt_reg == MS_TENTH_LAST) begin
                ms_cnt_next = '0;
                if (tenth_reg != TRIP_DELAY_MAX) tenth_next = tenth_reg + 1'b1;
            end else begin
                ms_cnt_next = ms_cnt_reg + 1'b1;
            end
        end
        // Strictly longer than the delay: trip on the first ms tick after the count reaches it
        if (!restart && tenth_reg >= delay_c && ms_tick) begin
            trip_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ms_cnt_reg    <= '0;
            tenth_reg     <= '0;
            trip_reg      <= 1'b0;
            kind_last_reg <= AIO_TRIP_OFF;
        end else begin
            ms_cnt_reg    <= ms_cnt_next;
            tenth_reg     <= tenth_next;
            trip_reg      <= trip_next;
            kind_last_reg <= kind_c;
        end
    end

    // Output source mapping to full-scale counts
    function automatic logic [DAC_W-1:0] map_pct(input logic [31:0] v, input logic [31:0] fs);
        logic [43:0] prod;
        prod = 44'(v) * 44'(DAC_FULL);
        if (v >= fs) map_pct = DAC_FULL;
        else map_pct = DAC_W'(prod / 44'(fs));
    endfunction

    logic [DAC_W-1:0] src_val;
    always_comb begin
        case (param_output_source_select)
            SRC_CUR100:  src_val = map_pct(32'(current_pct), FS_CUR100);
            SRC_CUR200:  src_val = map_pct(32'(current_pct), FS_CUR200);
            SRC_CUR800:  src_val = map_pct(32'(current_pct), FS_CUR800);
            SRC_VOLT150: src_val = map_pct(32'(voltage_pct), FS_VOLT150);
            SRC_OL150:   src_val = map_pct(32'(thermal_load_content), FS_OL150);
            SRC_KW10:    src_val = map_pct(power_w, FS_KW10);
            SRC_KW100:   src_val = map_pct(power_w, FS_KW100);
            SRC_MW1:     src_val = map_pct(power_w, FS_MW1);
            SRC_MW10:    src_val = map_pct(power_w, FS_MW10);
            SRC_AIN:     src_val = DAC_W'(scaled_w);
            SRC_FIRING:  src_val = map_pct(32'(firing_pct), FS_FIRING);
            SRC_CAL:     src_val = DAC_FULL;
            default:     src_val = '0;
        endcase
    end

    // Refresh counter; output only moves on 25 ms boundaries
    logic [REF_CNT_W-1:0] ref_cnt_reg;
    logic [REF_CNT_W-1:0] ref_cnt_next;
    logic [DAC_W-1:0]     aout_reg;
    logic [DAC_W-1:0]     aout_next;
    logic                 upd_reg;
    logic                 upd_next;
    logic [ADC_W-1:0]     scaled_reg;
    always_comb begin
        ref_cnt_next = ref_cnt_reg;
        aout_next    = aout_reg;
        upd_next     = 1'b0;
        if (ms_tick) begin
            if (ref_cnt_reg == REFRESH_LAST) begin
                ref_cnt_next = '0;
                aout_next    = src_val;
                upd_next     = 1'b1;
            end else begin
                ref_cnt_next = ref_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_cnt_reg <= '0;
            aout_reg    <= '0;
            upd_reg     <= 1'b0;
            scaled_reg  <= '0;
        end else begin
            ref_cnt_reg <= ref_cnt_next;
            aout_reg    <= aout_next;
            upd_reg     <= upd_next;
            scaled_reg  <= scaled_w;
        end
    end

    assign ain_scaled  = scaled_reg;
    assign input_trip  = trip_reg;
    assign aout_value  = aout_reg;
    assign aout_update = upd_reg;

    // Assertions; trip checks look one edge back since trip_reg follows trip_next
    stopped_no_trip_a: assert property (@(posedge clk) disable iff (!rst_b)
        !run_s2_reg |=> !trip_reg)
        else $error("trip while motor stopped");
    trip_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
        trip_reg && run_s2_reg |=> trip_reg)
        else $error("trip dropped while running");
    off_no_trip_a: assert property (@(posedge clk) disable iff (!rst_b)
        (kind_c == AIO_TRIP_OFF) && !trip_reg |=> !trip_reg)
        else $error("trip with kind off");
    trip_needs_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(trip_reg) |-> $past(tenth_reg) >= $past(delay_c))
        else $error("trip before delay");
    low_cond_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(trip_reg) && $past(kind_c) == AIO_TRIP_LOW |-> $past(below))
        else $error("low trip not below");
    high_cond_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(trip_reg) && $past(kind_c) == AIO_TRIP_HIGH |-> $past(above))
        else $error("high trip not above");
    timer_restart_a: assert property (@(posedge clk) disable iff (!rst_b)
        restart |=> tenth_reg == '0 && ms_cnt_reg == '0)
        else $error("timer not restarted");
    scale_clamp_a: assert property (@(posedge clk) disable iff (!rst_b)
        ain_hold_reg == '0 |-> scaled_w == '0)
        else $error("scaled reading not zero at zero input");
    cal_full_a: assert property (@(posedge clk) disable iff (!rst_b)
        upd_next && param_output_source_select == SRC_CAL |=> aout_reg == DAC_FULL)
        else $error("cal not full");
    off_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        upd_next && param_output_source_select == SRC_OFF |=> aout_reg == '0)
        else $error("output not off");
    ain_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        upd_next && param_output_source_select == SRC_AIN |=> aout_reg == $past(scaled_w))
        else $error("output not the scaled input reading");
    refresh_only_a: assert property (@(posedge clk) disable iff (!rst_b)
        !upd_reg |-> aout_reg == $past(aout_reg))
        else $error("output moved between refreshes");
    update_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        upd_reg |=> !upd_reg)
        else $error("update pulse longer than one cycle");
endmodule
`default_nettype wire

/* tb/aio_sensor_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Process sensor feeding the input converter; slow mode ramps like a lagging transmitter
module aio_sensor_model
    import aio_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [ADC_W-1:0] level,
    input  wire logic             slow,
    output logic      [ADC_W-1:0] ain_raw
);
    logic [ADC_W-1:0] code_reg = '0;

    assign ain_raw = code_reg;

    // Codes change between edges because the converter is not tied to our clock
    always @(posedge clk) begin
        #3;
        if (!slow || ((code_reg > level) ? code_reg - level : level - code_reg) < 12'h040) begin
            code_reg <= level;
        end else if (code_reg < level) begin
            code_reg <= code_reg + 12'h040;
        end else begin
            code_reg <= code_reg - 12'h040;
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// Bench for the analog input scaling, trip comparator and output selector
module tb
    import aio_pkg::*;
;
    logic                 clk, rst_b, slow, motor_running, ain_trip, aout_update;
    logic [ADC_W-1:0]     level, ain_raw, ain_scaled;
    logic [DAC_W-1:0]     aout_value;
    logic [1:0]           kind;
    logic [PCT_W-1:0]     thr, span, shift;
    logic [TENTHS_W-1:0]  dly;
    logic [SRC_SEL_W-1:0] src;
    logic [15:0]          cur, volt, therm, fir;
    logic [31:0]          pwr;
    int                   failures = 0;
    int                   samples_checked = 0;
    // Scaling table: level, offset, span, expected reading
    logic [11:0]          sc_lvl[7]  = '{12'h800, 12'h333, 12'h000, 12'hfff, 12'h600, 12'h999, 12'h200};
    logic [6:0]           sc_off[7]  = '{7'h00, 7'h14, 7'h14, 7'h00, 7'h00, 7'h14, 7'h14};
    logic [6:0]           sc_span[7] = '{7'h64, 7'h64, 7'h64, 7'h32, 7'h32, 7'h50, 7'h64};
    logic [11:0]          sc_exp[7]  = '{12'h800, 12'h000, 12'h000, 12'hfff, 12'hc00, 12'h7ff, 12'h000};

    // Small tick divider keeps 100 ms at 400 cycles
    aio_core #(.TICK_DIV(4)) i_dut (
        .clk(clk), .rst_b(rst_b), .ain_raw(ain_raw), .motor_running(motor_running),
        .param_input_trip_kind(kind), .param_input_trip_threshold(thr), .param_input_trip_delay(dly),
        .param_input_scale_span(span), .param_input_zero_shift(shift), .param_output_source_select(src),
        .current_pct(cur), .voltage_pct(volt), .thermal_load_content(therm), .power_w(pwr),
        .firing_pct(fir), .ain_scaled(ain_scaled), .input_trip(ain_trip), .aout_value(aout_value),
        .aout_update(aout_update)
    );

    aio_sensor_model i_sensor (.clk(clk), .level(level), .slow(slow), .ain_raw(ain_raw));

    // Free-running 8 ns clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Watchdog sized well above the expected nine thousand cycles
    initial begin
        #(40000 * 8);
        failures++;
        tally_and_finish();
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Tolerance covers rounding choices in the divider paths
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol);
        logic [31:0] d;
        samples_checked++;
        d = (got > exp) ? got - exp : exp - got;
        if ($isunknown(got) || d > tol) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Stop the motor to restart the timer, then run and time the trip
    task automatic trip_run(input logic [1:0] k, input logic [11:0] v, input int d, input logic exp_trip);
        int n;
        motor_running = 1'b0;
        kind = k;
        level = v;
        dly = d[TENTHS_W-1:0];
        cyc(8);
        motor_running = 1'b1;
        n = 0;
        while (ain_trip !== 1'b1 && n < d * 400 + 80) begin
            cyc(1);
            n++;
        end
        check(ain_trip, exp_trip, 0);
        if (exp_trip) check(n, d * 400 + 40, 39);
    endtask

    task automatic wait_update(output int n);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (aout_update !== 1'b1 && n < 200);
    endtask

    // Full-scale fractions for each output source with the stimulus below
    function automatic int out_exp(input int c);
        case (c)
            1, 4, 5, 6, 11: return 2047;
            2: return 1023;
            3: return 255;
            7: return 204;
            8: return 20;
            9: return 2;
            10: return 2048;
            12: return 4095;
            default: return 0;
        endcase
    endfunction

    task automatic tally_and_finish();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence: scaling, trip comparator, output selector
    initial begin
        int n;
        rst_b = 1'b0;
        level = '0;
        slow = 1'b1;
        motor_running = 1'b0;
        kind = AIO_TRIP_OFF;
        thr = TRIP_LEVEL_DEFAULT_PCT;
        dly = TRIP_DELAY_DEFAULT;
        span = PCT_HUNDRED;
        shift = 7'h00;
        src = SRC_OFF;
        cur = 16'h0032;
        volt = 16'h004b;
        therm = 16'h004b;
        pwr = 32'h00001388;
        fir = 16'h0032;
        cyc(12);
        rst_b = 1'b1;
        cyc(2);
        check(ain_trip, 1'b0, 0);
        check(aout_value, 12'h000, 0);
        check(aout_update, 1'b0, 0);
        for (int i = 0; i < 7; i++) begin
            level = sc_lvl[i];
            shift = sc_off[i];
            span = sc_span[i];
            cyc(80);
            check(ain_scaled, sc_exp[i], 3);
        end
        // Trip tests run with a 20 percent offset and 50 percent span to show they are ignored
        slow = 1'b0;
        shift = 7'h14;
        span = 7'h32;
        trip_run(AIO_TRIP_LOW, 12'h780, 1, 1'b1);
        motor_running = 1'b0;
        cyc(6);
        check(ain_trip, 1'b0, 0);
        trip_run(AIO_TRIP_HIGH, 12'h900, 2, 1'b1);
        trip_run(AIO_TRIP_HIGH, 12'h780, 1, 1'b0);
        trip_run(AIO_TRIP_OFF, 12'h000, 1, 1'b0);
        trip_run(2'h3, 12'h000, 1, 1'b0);
        thr = 7'h00;
        trip_run(AIO_TRIP_LOW, 12'h000, 1, 1'b0);
        thr = PCT_HUNDRED;
        trip_run(AIO_TRIP_HIGH, 12'hfff, 1, 1'b0);
        thr = TRIP_LEVEL_DEFAULT_PCT;
        motor_running = 1'b0;
        kind = AIO_TRIP_LOW;
        level = 12'h100;
        cyc(600);
        check(ain_trip, 1'b0, 0);
        // Lapses and a kind change part way must both restart the delay
        motor_running = 1'b1;
        cyc(300);
        level = 12'h900;
        cyc(20);
        level = 12'h100;
        cyc(300);
        kind = AIO_TRIP_HIGH;
        cyc(4);
        kind = AIO_TRIP_LOW;
        cyc(300);
        check(ain_trip, 1'b0, 0);
        cyc(150);
        check(ain_trip, 1'b1, 0);
        motor_running = 1'b0;
        level = 12'h800;
        shift = 7'h00;
        span = PCT_HUNDRED;
        cyc(80);
        for (int c = 0; c < 14; c++) begin
            src = c[3:0];
            wait_update(n);
            wait_update(n);
            check(n, 100, 0);
            check(aout_value, out_exp(c), 2);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
